/* File: rtl/dapwm_consts.vh */
`ifndef DAPWM_CONSTS_VH
`define DAPWM_CONSTS_VH
// What this block does
// - One shared 12-bit counter; select bit adds a second counter for outputs 2, 3
// - In dual mode outputs 2, 3 take their period from counter two and its reload
// - Pulse rate is counter clock divided by 4096 minus the reload value
// - After reset every counter starts from zero
// - Duty preloads are copied to active duty on overflow when the transfer bit is set
// - Transfer bit one serves counter one outputs, transfer bit two counter two outputs
// - Overflow drives outputs high; a match with active duty drives them low
// - One polarity bit per output; with transfer set it changes at next overflow
// - Reload zero gives 1/4096 steps; duty 4095 gives 100% on the fast clock, 0% comes from the polarity bit
// - Each output has its own enable bit in the output control register
// - Dead time keeps outputs 0 and 1 apart by the 7-bit value times counter clock period
// - Output 0 rises a dead time after overflow; output 1 a dead time after match
// - The whole dead-time register is buffered and taken only at overflow
// - Dead time enabled with a zero value holds the outputs at reset state
// - Outputs 0 and 1 stay apart only while neither polarity is inverted
// - No dead time while counting on the slow timebase
// - The break pin acts only after its enable bit is set
// - The break level select bit chooses the active level of the break pin
// - An active break level sets the break flag and forces enabled outputs to pattern
// - Software may raise the break by writing the break flag
// - Two break enable bits, one per counter, gate the break on its outputs
// - Single mode uses break enable one for all; dual mode enable two for outputs 2, 3
// - In break, enabled counters clear, reload and duty registers reset, counting stops
// - Clearing the break flag hands the pins back to the timer
`define DAPWM_ADDR_CTRL 8'h00
`define DAPWM_ADDR_RELOAD1 8'h04
`define DAPWM_ADDR_RELOAD2 8'h08
`define DAPWM_ADDR_DUTY0 8'h0C
`define DAPWM_ADDR_DUTY1 8'h10
`define DAPWM_ADDR_DUTY2 8'h14
`define DAPWM_ADDR_DUTY3 8'h18
`define DAPWM_ADDR_OUTCTRL 8'h1C
`define DAPWM_ADDR_DEADTIME 8'h20
`define DAPWM_ADDR_BRKCTRL 8'h24
`define DAPWM_ADDR_BRKEN 8'h28
`define DAPWM_ADDR_STATUS 8'h2C
`define DAPWM_CTRL_SEL2 0
`define DAPWM_CTRL_FIRST_TRANSFER_BIT 1
`define DAPWM_CTRL_SECOND_TRANSFER_BIT 2
`define DAPWM_CTRL_FORCE1 3
`define DAPWM_CTRL_FORCE2 4
`define DAPWM_CTRL_SLOWTB 5
`define DAPWM_BRK_PINEN 0
`define DAPWM_BRK_LEVEL 1
`define DAPWM_BRK_ACTIVE 2
`define DAPWM_STAT_OVF1 28
`define DAPWM_STAT_OVF2 29
`define DAPWM_DT_EN 7
`define DAPWM_CNT_MAX 12'hFFF
`define DAPWM_CNT_RST 12'h000
`define DAPWM_DT_RST 8'h00
`define DAPWM_TRAN_RST 1'b1
`endif

/* File: rtl/dapwm_dtg.v */
`include "dapwm_consts.vh"

module dapwm_dtg (
  input wire clk,
  input wire sys_rst,
  input wire tick,
  input wire raw,
  input wire [6:0] dead_time_value,
  output wire lead_out,
  output wire lag_out
);
  reg raw_q;
  reg [6:0] gap_q;
  wire done;

  assign done = (gap_q == dead_time_value);
  // Output 0 follows the rising edge late, output 1 the falling edge late
  assign lead_out = raw_q & done;
  assign lag_out = ~raw_q & done;

  always @(posedge clk) begin
    if (sys_rst) begin
      raw_q <= 1'b0;
      gap_q <= 7'h00;
    end else begin
      raw_q <= raw;
      if (raw != raw_q) begin
        gap_q <= 7'h00;
      end else if (tick && !done) begin
        gap_q <= gap_q + 7'h01;
      end
    end
  end
endmodule // dapwm_dtg

/* File: rtl/dapwm_top.v */
// Local design decisions: the address map and the APB slave port.
`include "dapwm_consts.vh"

module dapwm_top (
  input wire clk,
  input wire sys_rst,
  input wire psel,
  input wire penable,
  input wire pwrite,
  input wire [7:0] paddr,
  input wire [31:0] pwdata,
  output reg [31:0] prdata,
  output wire pready,
  output wire pslverr,
  input wire break_pin,
  input wire timebase_tick,
  output reg [3:0] pulse_output_n
);
  reg second_counter_select_q;
  reg first_transfer_bit_q;
  reg second_transfer_bit_q;
  reg slow_timebase_q;
  reg [11:0] first_reload_value_q;
  reg [11:0] second_reload_value_q;
  reg [11:0] first_up_counter_q;
  reg [11:0] second_up_counter_q;
  reg [11:0] duty_pre_q [0:3];
  reg [11:0] duty_act_q [0:3];
  reg [3:0] output_enable_q;
  reg [3:0] polarity_q;
  reg [3:0] polarity_act_q;
  reg [7:0] dead_time_register_q;
  reg [7:0] dead_time_act_q;
  reg break_pin_enable_q;
  reg break_level_select_q;
  reg break_active_q;
  reg [3:0] break_pattern_q;
  reg counter1_break_enable_q;
  reg counter2_break_enable_q;
  reg [1:0] ovf_seen_q;
  reg [3:0] raw_q;
  reg [31:0] rdata;
  reg hit;

  wire wr;
  wire wr_ctrl;
  wire wr_brk;
  wire tick;
  wire brk1;
  wire brk2;
  wire brk_any;
  wire run1;
  wire run2;
  wire ovf1;
  wire ovf2;
  wire break_level_hit;
  wire dt_on;
  wire dt_zero;
  wire dt_lead;
  wire dt_lag;
  wire [3:0] stage;
  wire [3:0] shaped;
  wire [3:0] ch_brk;
  wire [3:0] final_out;

  assign wr = psel & penable & pwrite;
  assign wr_ctrl = wr & (paddr == `DAPWM_ADDR_CTRL);
  assign wr_brk = wr & (paddr == `DAPWM_ADDR_BRKCTRL);
  assign pready = 1'b1;
  assign pslverr = psel & penable & ~hit;

  // Count enable from the fast clock or the slow timebase tick
  assign tick = slow_timebase_q ? timebase_tick : 1'b1;

  // Break gating per counter
  assign brk1 = break_active_q & counter1_break_enable_q;
  assign brk2 = break_active_q & counter2_break_enable_q & second_counter_select_q;
  assign brk_any = brk1 | brk2;

  assign run1 = tick & ~brk1;
  assign run2 = tick & ~brk2 & second_counter_select_q;

  // Overflow at top count, or a forced overflow from software
  assign ovf1 = (run1 & (first_up_counter_q == `DAPWM_CNT_MAX)) |
                (wr_ctrl & pwdata[`DAPWM_CTRL_FORCE1] & ~brk1);
  assign ovf2 = (run2 & (second_up_counter_q == `DAPWM_CNT_MAX)) |
                (wr_ctrl & pwdata[`DAPWM_CTRL_FORCE2] & ~brk2 &
                 second_counter_select_q);

  // Counter one
  always @(posedge clk) begin
    if (sys_rst) begin
      first_up_counter_q <= `DAPWM_CNT_RST;
    end else if (brk1) begin
      first_up_counter_q <= `DAPWM_CNT_RST;
    end else if (ovf1) begin
      first_up_counter_q <= first_reload_value_q;
    end else if (run1) begin
      first_up_counter_q <= first_up_counter_q + 12'h001;
    end
  end

  // Counter two, idle in single-counter mode
  always @(posedge clk) begin
    if (sys_rst) begin
      second_up_counter_q <= `DAPWM_CNT_RST;
    end else if (brk2 || !second_counter_select_q) begin
      second_up_counter_q <= `DAPWM_CNT_RST;
    end else if (ovf2) begin
      second_up_counter_q <= second_reload_value_q;
    end else if (run2) begin
      second_up_counter_q <= second_up_counter_q + 12'h001;
    end
  end

  // Control register and transfer bits
  always @(posedge clk) begin
    if (sys_rst) begin
      second_counter_select_q <= 1'b0;
      slow_timebase_q <= 1'b0;
      first_transfer_bit_q <= `DAPWM_TRAN_RST;
      second_transfer_bit_q <= `DAPWM_TRAN_RST;
    end else begin
      if (wr_ctrl) begin
        second_counter_select_q <= pwdata[`DAPWM_CTRL_SEL2];
        slow_timebase_q <= pwdata[`DAPWM_CTRL_SLOWTB];
      end
      // A software write wins over the clear at overflow
      if (wr_ctrl) begin
        first_transfer_bit_q <= pwdata[`DAPWM_CTRL_FIRST_TRANSFER_BIT];
      end else if (ovf1) begin
        first_transfer_bit_q <= 1'b0;
      end
      if (wr_ctrl) begin
        second_transfer_bit_q <= pwdata[`DAPWM_CTRL_SECOND_TRANSFER_BIT];
      end else if (ovf2) begin
        second_transfer_bit_q <= 1'b0;
      end
    end
  end

  // Reload registers, reset during break
  always @(posedge clk) begin
    if (sys_rst || brk_any) begin
      first_reload_value_q <= `DAPWM_CNT_RST;
      second_reload_value_q <= `DAPWM_CNT_RST;
    end else begin
      if (wr && paddr == `DAPWM_ADDR_RELOAD1) begin
        first_reload_value_q <= pwdata[11:0];
      end
      if (wr && paddr == `DAPWM_ADDR_RELOAD2) begin
        second_reload_value_q <= pwdata[11:0];
      end
    end
  end

  // Per-output channel logic
  genvar i;
  generate
    for (i = 0; i < 4; i = i + 1) begin : g_ch
      wire in_grp2;
      wire ch_ovf;
      wire ch_tran;
      wire [11:0] ch_cnt;

      assign in_grp2 = second_counter_select_q && (i >= 2);
      assign ch_ovf = in_grp2 ? ovf2 : ovf1;
      assign ch_tran = in_grp2 ? second_transfer_bit_q : first_transfer_bit_q;
      assign ch_cnt = in_grp2 ? second_up_counter_q : first_up_counter_q;
      assign ch_brk[i] = in_grp2 ? brk2 : brk1;

      always @(posedge clk) begin
        if (sys_rst || brk_any) begin
          duty_pre_q[i] <= `DAPWM_CNT_RST;
          duty_act_q[i] <= `DAPWM_CNT_RST;
        end else begin
          if (wr && paddr == (`DAPWM_ADDR_DUTY0 + 8'h04 * i)) begin
            duty_pre_q[i] <= pwdata[11:0];
          end
          if (ch_ovf && ch_tran) begin
            duty_act_q[i] <= duty_pre_q[i];
          end
        end
      end

      // Polarity waits for overflow while transfer is set, else follows at once
      always @(posedge clk) begin
        if (sys_rst) begin
          polarity_act_q[i] <= 1'b0;
        end else if (!ch_tran || ch_ovf) begin
          polarity_act_q[i] <= polarity_q[i];
        end
      end

      // Set on overflow, cleared on duty match
      always @(posedge clk) begin
        if (sys_rst || ch_brk[i]) begin
          raw_q[i] <= 1'b0;
        end else if (ch_ovf) begin
          raw_q[i] <= 1'b1;
        end else if (ch_cnt == duty_act_q[i]) begin
          raw_q[i] <= 1'b0;
        end
      end

      // Polarity sits after dead time and before enable and break
      assign shaped[i] = stage[i] ^ polarity_act_q[i];
      assign final_out[i] = ~output_enable_q[i] ? 1'b0 :
                            ch_brk[i] ? break_pattern_q[i] :
                            (dt_zero ? 1'b0 : shaped[i]);
    end
  endgenerate

  // Dead-time stage on outputs 0 and 1
  assign dt_on = dead_time_act_q[`DAPWM_DT_EN] & ~slow_timebase_q;
  assign dt_zero = dt_on & (dead_time_act_q[6:0] == 7'h00);

  dapwm_dtg u_dtg (
    .clk(clk),
    .sys_rst(sys_rst),
    .tick(run1),
    .raw(raw_q[0]),
    .dead_time_value(dead_time_act_q[6:0]),
    .lead_out(dt_lead),
    .lag_out(dt_lag)
  );

  assign stage[0] = dt_on ? dt_lead : raw_q[0];
  assign stage[1] = dt_on ? dt_lag : raw_q[1];
  assign stage[3:2] = raw_q[3:2];

  // Output control, dead-time and break configuration
  always @(posedge clk) begin
    if (sys_rst) begin
      output_enable_q <= 4'h0;
      polarity_q <= 4'h0;
      dead_time_register_q <= `DAPWM_DT_RST;
      dead_time_act_q <= `DAPWM_DT_RST;
      break_pin_enable_q <= 1'b0;
      break_level_select_q <= 1'b0;
      break_pattern_q <= 4'h0;
      counter1_break_enable_q <= 1'b0;
      counter2_break_enable_q <= 1'b0;
    end else begin
      if (wr && paddr == `DAPWM_ADDR_OUTCTRL) begin
        output_enable_q <= pwdata[3:0];
        polarity_q <= pwdata[7:4];
      end
      if (wr && paddr == `DAPWM_ADDR_DEADTIME) begin
        dead_time_register_q <= pwdata[7:0];
      end
      if (ovf1) begin
        dead_time_act_q <= dead_time_register_q;
      end
      if (wr_brk) begin
        break_pin_enable_q <= pwdata[`DAPWM_BRK_PINEN];
        break_level_select_q <= pwdata[`DAPWM_BRK_LEVEL];
        break_pattern_q <= pwdata[7:4];
      end
      if (wr && paddr == `DAPWM_ADDR_BRKEN) begin
        counter1_break_enable_q <= pwdata[0];
        counter2_break_enable_q <= pwdata[1];
      end
    end
  end

  // Break flag: pin level or software sets it, software clears it
  assign break_level_hit = break_pin_enable_q &
                           (break_pin == break_level_select_q);

  always @(posedge clk) begin
    if (sys_rst) begin
      break_active_q <= 1'b0;
    end else if (break_level_hit) begin
      break_active_q <= 1'b1;
    end else if (wr_brk) begin
      break_active_q <= pwdata[`DAPWM_BRK_ACTIVE];
    end
  end

  // Sticky overflow flags, write one to clear, set wins
  always @(posedge clk) begin
    if (sys_rst) begin
      ovf_seen_q <= 2'b00;
    end else begin
      if (ovf1) begin
        ovf_seen_q[0] <= 1'b1;
      end else if (wr && paddr == `DAPWM_ADDR_STATUS && pwdata[`DAPWM_STAT_OVF1]) begin
        ovf_seen_q[0] <= 1'b0;
      end
      if (ovf2) begin
        ovf_seen_q[1] <= 1'b1;
      end else if (wr && paddr == `DAPWM_ADDR_STATUS && pwdata[`DAPWM_STAT_OVF2]) begin
        ovf_seen_q[1] <= 1'b0;
      end
    end
  end

  // Registered pin drivers
  always @(posedge clk) begin
    if (sys_rst) begin
      pulse_output_n <= 4'h0;
    end else begin
      pulse_output_n <= final_out;
    end
  end

  // Read mux
  always @* begin
    rdata = 32'h0000_0000;
    hit = 1'b1;
    case (paddr)
      `DAPWM_ADDR_CTRL: begin
        rdata[`DAPWM_CTRL_SEL2] = second_counter_select_q;
        rdata[`DAPWM_CTRL_FIRST_TRANSFER_BIT] = first_transfer_bit_q;
        rdata[`DAPWM_CTRL_SECOND_TRANSFER_BIT] = second_transfer_bit_q;
        rdata[`DAPWM_CTRL_SLOWTB] = slow_timebase_q;
      end
      `DAPWM_ADDR_RELOAD1: rdata[11:0] = first_reload_value_q;
      `DAPWM_ADDR_RELOAD2: rdata[11:0] = second_reload_value_q;
      `DAPWM_ADDR_DUTY0: rdata[11:0] = duty_pre_q[0];
      `DAPWM_ADDR_DUTY1: rdata[11:0] = duty_pre_q[1];
      `DAPWM_ADDR_DUTY2: rdata[11:0] = duty_pre_q[2];
      `DAPWM_ADDR_DUTY3: rdata[11:0] = duty_pre_q[3];
      `DAPWM_ADDR_OUTCTRL: rdata[7:0] = {polarity_q, output_enable_q};
      `DAPWM_ADDR_DEADTIME: rdata[7:0] = dead_time_register_q;
      `DAPWM_ADDR_BRKCTRL: begin
        rdata[7:4] = break_pattern_q;
        rdata[`DAPWM_BRK_PINEN] = break_pin_enable_q;
        rdata[`DAPWM_BRK_LEVEL] = break_level_select_q;
        rdata[`DAPWM_BRK_ACTIVE] = break_active_q;
      end
      `DAPWM_ADDR_BRKEN: rdata[1:0] = {counter2_break_enable_q, counter1_break_enable_q};
      `DAPWM_ADDR_STATUS: begin
        rdata[11:0] = first_up_counter_q;
        rdata[27:16] = second_up_counter_q;
        rdata[`DAPWM_STAT_OVF1] = ovf_seen_q[0];
        rdata[`DAPWM_STAT_OVF2] = ovf_seen_q[1];
      end
      default: hit = 1'b0;
    endcase
  end

  // Read data is captured in the setup phase so it is stable from a flop
  always @(posedge clk) begin
    if (sys_rst) begin
      prdata <= 32'h0000_0000;
    end else if (psel && !penable) begin
      prdata <= rdata;
    end
  end
endmodule // dapwm_top

/* File: verification/dapwm_props.sv */
module dapwm_props (
  input wire clk,
  input wire sys_rst,
  input wire psel,
  input wire penable,
  input wire pwrite,
  input wire [7:0] paddr,
  input wire [31:0] pwdata,
  input wire [31:0] prdata,
  input wire pready,
  input wire pslverr,
  input wire break_pin,
  input wire timebase_tick,
  input wire [3:0] pulse_output_n
);
  timeunit 1ns;
  timeprecision 1ps;
  reg [7:0] oc_q, dt_q, bk_q;
  reg [1:0] be_q;
  reg sel2_q, brk_q;
  wire wr = psel && penable && pwrite;
  wire rd = psel && penable && !pwrite;
  wire hit = bk_q[0] && (break_pin == bk_q[1]);
  wire on1 = brk_q && be_q[0];
  // Software view of the written control fields and the break flag
  always @(posedge clk) begin
    if (sys_rst) begin
      oc_q <= 8'h00;
      dt_q <= 8'h00;
      bk_q <= 8'h00;
      be_q <= 2'b00;
      sel2_q <= 1'b0;
      brk_q <= 1'b0;
    end else begin
      if (wr && paddr == 8'h1C) oc_q <= pwdata[7:0];
      if (wr && paddr == 8'h20) dt_q <= pwdata[7:0];
      if (wr && paddr == 8'h24) bk_q <= pwdata[7:0];
      if (wr && paddr == 8'h28) be_q <= pwdata[1:0];
      if (wr && paddr == 8'h00) sel2_q <= pwdata[0];
      brk_q <= ((wr && paddr == 8'h24) ? pwdata[2] : brk_q) | hit;
    end
  end
  default clocking @(posedge clk); endclocking
  default disable iff (sys_rst);
  property p_brk1;
    (brk_q && be_q[0] && !sel2_q) [*2] |->
      pulse_output_n == ($past(bk_q[7:4]) & $past(oc_q[3:0]));
  endproperty
  a_brk1: assert property (p_brk1) else $error("break pattern wrong");
  property p_brk2;
    (brk_q && be_q[1] && sel2_q) [*2] |->
      pulse_output_n[3:2] == ($past(bk_q[7:6]) & $past(oc_q[3:2]));
  endproperty
  a_brk2: assert property (p_brk2) else $error("dual break wrong");
  property p_oe;
    (~oc_q[3:0] & ~$past(oc_q[3:0]) & pulse_output_n) == 4'h0;
  endproperty
  a_oe: assert property (p_oe) else $error("disabled output high");
  property p_bflag;
    rd && paddr == 8'h24 |-> prdata[2] == $past(brk_q);
  endproperty
  a_bflag: assert property (p_bflag) else $error("break flag wrong");
  property p_ocrb;
    rd && paddr == 8'h1C |-> prdata[7:0] == $past(oc_q);
  endproperty
  a_ocrb: assert property (p_ocrb) else $error("output control readback");
  property p_dtrb;
    rd && paddr == 8'h20 |-> prdata[7:0] == $past(dt_q);
  endproperty
  a_dtrb: assert property (p_dtrb) else $error("dead time readback");
  property p_zero;
    rd && (paddr == 8'h04 || paddr == 8'h2C) && $past(on1, 2) && $past(on1, 3)
      |-> prdata[11:0] == 12'h000;
  endproperty
  a_zero: assert property (p_zero) else $error("not cleared in break");
  property p_rst;
    disable iff (1'b0) sys_rst |=> pulse_output_n == 4'h0 && prdata == 32'h0000_0000;
  endproperty
  a_rst: assert property (p_rst) else $error("reset state wrong");
  c_brk: cover property (brk_q && be_q[0]);
  c_dual: cover property (brk_q && sel2_q);
  c_stat: cover property (rd && paddr == 8'h2C);
endmodule // dapwm_props

bind dapwm_top dapwm_props u_props (.clk(clk), .sys_rst(sys_rst), .psel(psel),
  .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
  .pready(pready), .pslverr(pslverr), .break_pin(break_pin),
  .timebase_tick(timebase_tick), .pulse_output_n(pulse_output_n));

/* File: verification/dapwm_bridge.sv */
module dapwm_bridge (
  input wire clk,
  input wire break_req,
  input wire [3:0] pulse_output_n,
  output reg break_pin,
  output reg [15:0] overlap_cnt
);
  timeunit 1ns;
  timeprecision 1ps;
  initial break_pin = 1'b0;
  initial overlap_cnt = 16'h0000;
  // Break line driven level, counts cycles with both bridge gates on
  always @(posedge clk) begin
    break_pin <= break_req;
    if (pulse_output_n[0] && pulse_output_n[1]) overlap_cnt <= overlap_cnt + 16'h0001;
  end
endmodule // dapwm_bridge

/* File: verification/tb_dual_autoreload_pwm_timer.sv */
module tb_dual_autoreload_pwm_timer;
  timeunit 1ns;
  timeprecision 1ps;
  reg clk = 1'b0;
  reg sys_rst = 1'b1;
  reg psel = 1'b0, penable = 1'b0, pwrite = 1'b0, break_req = 1'b0, tbt = 1'b0;
  reg [7:0] paddr = 8'h00;
  reg [31:0] pwdata = 32'h0000_0000;
  reg [31:0] q;
  reg e;
  wire [31:0] prdata;
  wire pready, pslverr, break_pin;
  wire [3:0] pwm;
  wire [15:0] ovl;
  integer err_total = 0, n_tests = 0, cyc = 0, hi, per, hb;
  dapwm_top u_dut (.clk(clk), .sys_rst(sys_rst), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .break_pin(break_pin), .timebase_tick(tbt), .pulse_output_n(pwm));
  dapwm_bridge u_bridge (.clk(clk), .break_req(break_req), .pulse_output_n(pwm),
    .break_pin(break_pin), .overlap_cnt(ovl));
  initial forever #2 clk = ~clk;
  task close_out;
    begin
      $display("Comparisons %0d, mismatches %0d", n_tests, err_total);
      if (err_total == 0 && n_tests > 0) $display("Regression OK");
      else $display("Regression broken");
      $finish;
    end
  endtask
  always @(posedge clk) begin
    cyc = cyc + 1;
    // Slow timebase ticks on every other clock
    tbt <= ~tbt;
    if (cyc == 60000) begin
      err_total = err_total + 1;
      close_out;
    end
  end
  task chk(input [31:0] v, input [31:0] x);
    begin
      n_tests = n_tests + 1;
      if (v !== x) begin
        err_total = err_total + 1;
        $display("CHECK FAILED at %0t: got %h expected %h", $time, v, x);
      end
    end
  endtask
  // One APB transfer, setup then access until pready
  task xf(input w, input [7:0] a, input [31:0] d);
    begin
      @(posedge clk);
      psel <= 1'b1;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge clk);
      penable <= 1'b1;
      @(posedge clk);
      while (pready !== 1'b1) @(posedge clk);
      q = prdata;
      e = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
    end
  endtask
  task tk;
    begin
      @(posedge clk);
      #1;
    end
  endtask
  task idle(input integer n);
    repeat (n) tk;
  endtask
  // High time and period of one output, rise to rise
  task meas(input integer ch);
    integer k;
    begin
      k = 0;
      hi = 0;
      per = 0;
      while (pwm[ch] !== 1'b0 && k < 9000) begin tk; k = k + 1; end
      while (pwm[ch] !== 1'b1 && k < 9000) begin tk; k = k + 1; end
      while (pwm[ch] === 1'b1 && k < 9000) begin tk; k = k + 1; hi = hi + 1; end
      per = hi;
      while (pwm[ch] === 1'b0 && k < 9000) begin tk; k = k + 1; per = per + 1; end
    end
  endtask
  initial begin
    repeat (20) @(posedge clk);
    sys_rst <= 1'b0;
    xf(0, 8'h2C, 0); chk(q[11:0] < 12'h008, 1);
    xf(0, 8'h00, 0); chk(q, 32'h0000_0006);
    xf(0, 8'h30, 0); chk({q[30:0], e}, 1);
    $display("Test reset done");
    xf(1, 8'h04, 4000); xf(1, 8'h0C, 4048); xf(1, 8'h1C, 1); xf(1, 8'h00, 2);
    meas(0); meas(0); chk(per, 96);
    hb = hi;
    xf(1, 8'h0C, 4060); xf(1, 8'h00, 8'h0A);
    meas(0); meas(0); chk(hi - hb, 12);
    hb = hi;
    xf(1, 8'h0C, 4090); xf(1, 8'h00, 0);
    meas(0); meas(0); chk(hi, hb);
    xf(1, 8'h1C, 8'h11); meas(0); meas(0); chk(hi, 96 - hb);
    $display("Test duty done");
    xf(1, 8'h08, 4064); xf(1, 8'h14, 4080); xf(1, 8'h1C, 5); xf(1, 8'h00, 5);
    meas(2); meas(2); chk(per, 32);
    meas(0); chk(per, 96);
    $display("Test dual done");
    xf(1, 8'h00, 0); xf(1, 8'h1C, 3); xf(1, 8'h20, 8'h85);
    xf(0, 8'h20, 0); chk(q, 32'h0000_0085);
    meas(0); meas(0); chk(hi, hb - 5);
    meas(1); chk(hi, 96 - hb - 5);
    hi = ovl;
    idle(300); chk(ovl - hi, 0);
    // Slow timebase: half-rate steps and no dead time on output 0
    xf(1, 8'h00, 8'h20); meas(0); meas(0); chk(per, 192);
    chk(hi, 2 * hb - 1);
    xf(1, 8'h00, 0);
    xf(1, 8'h20, 8'h80); idle(250); chk(pwm[1:0], 0);
    $display("Test dead time done");
    xf(1, 8'h00, 1); xf(1, 8'h28, 3); xf(1, 8'h1C, 8'h0F); xf(1, 8'h24, 8'hA4);
    idle(3); chk(pwm, 4'hA);
    xf(1, 8'h04, 5); xf(0, 8'h04, 0); chk(q, 0);
    xf(1, 8'h24, 0); xf(0, 8'h2C, 0);
    hi = q[11:0];
    xf(0, 8'h2C, 0); chk(q[11:0] !== hi, 1);
    $display("Test soft break done");
    xf(1, 8'h00, 0); xf(1, 8'h28, 1); xf(1, 8'h24, 8'h52);
    break_req <= 1'b1;
    idle(4); xf(0, 8'h24, 0); chk(q[2], 0);
    xf(1, 8'h24, 8'h53); idle(3); chk(pwm, 4'h5);
    @(posedge clk);
    break_req <= 1'b0;
    xf(1, 8'h24, 0); xf(0, 8'h24, 0); chk(q[2], 0);
    xf(1, 8'h24, 8'h51); xf(0, 8'h24, 0); chk(q[2], 1);
    xf(1, 8'h24, 0); xf(1, 8'h24, 0);
    $display("Test pin break done");
    close_out;
  end
endmodule // tb_dual_autoreload_pwm_timer
